// *** pbc_pkg.sv ***
// Package for the basic control register block
package pbc_pkg;

  // ----------------------------------------
  // Register map and field positions
  // ----------------------------------------
  localparam logic [4:0] CTRL_ADDR = 5'h00;
  localparam int BIT_RESET = 15;
  localparam int BIT_LOOP = 14;
  localparam int BIT_SPEED = 13;
  localparam int BIT_ANEG = 12;
  localparam int BIT_PDOWN = 11;
  localparam int BIT_ISOL = 10;
  localparam int BIT_RESTART = 9;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_COLTEST = 7;
  localparam logic [15:0] WR_MASK = 16'hFF83;
  localparam logic [1:0] RSV_RESET = 2'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PD_WAIT_NS = 500;
  localparam int PD_WAIT_CYC = (PD_WAIT_NS * 1000) / CLK_PERIOD_PS;
  localparam int CHIP_RST_CYC = 16;

  // ----------------------------------------
  // Carried groups
  // ----------------------------------------
  typedef struct packed {
    logic speed;
    logic aneg;
    logic isolate;
    logic duplex;
  } pbc_strap_t;

  typedef struct packed {
    logic chip_reset;
    logic loopback;
    logic speed_100;
    logic full_duplex;
    logic aneg_en;
    logic aneg_restart;
    logic power_down;
    logic isolate;
    logic col_test;
    logic line_detach;
  } pbc_ctrl_t;

endpackage

// *** pbc_pulse_cnt.sv ***
// Countdown timer that holds a busy level for a set number of cycles
`timescale 1ns/10ps
module pbc_pulse_cnt #(
  parameter int CYCLES = 16
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic start_i,
  output logic busy_o
);

  localparam int CW = $clog2(CYCLES + 1);

  initial begin
    if (CYCLES < 1) begin
      $error("CYCLES must be at least one");
    end
  end

  logic [CW-1:0] cnt_r;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      if (start_i) begin
        cnt_r <= CW'(CYCLES);
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign busy_o = (cnt_r != '0);

endmodule // pbc_pulse_cnt

// *** pbc_ctrl_reg.sv ***
// Basic control register at management address 0
`timescale 1ns/10ps
module pbc_ctrl_reg #(
  parameter int CHIP_RST_CYCLES = pbc_pkg::CHIP_RST_CYC
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire pbc_pkg::pbc_strap_t strap_i,
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  input wire logic rx_dv_line_i,
  input wire logic [3:0] rxd_line_i,
  input wire logic col_line_i,
  output logic rx_dv_o,
  output logic [3:0] rxd_o,
  output logic col_o,
  output logic mii_oe_o,
  output logic line_tx_en_o,
  output logic pd_write_block_o,
  output pbc_pkg::pbc_ctrl_t ctrl_o
);

  initial begin
    if (CHIP_RST_CYCLES < 1) begin
      $error("CHIP_RST_CYCLES must be at least one");
    end
  end

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  logic loop_r;
  logic speed_r;
  logic aneg_r;
  logic pdown_r;
  logic isol_r;
  logic restart_r;
  logic duplex_r;
  logic coltest_r;
  logic [1:0] rsv_r;
  logic init_r;
  logic chip_rst_busy;
  logic pd_busy;
  logic [15:0] rd_nxt;

  wire hit = (reg_addr_i == pbc_pkg::CTRL_ADDR);
  wire wr_hit = reg_wr_i && hit && !chip_rst_busy;
  wire rst_req = wr_hit && reg_wdata_i[pbc_pkg::BIT_RESET];
  wire pd_clear = wr_hit && pdown_r && !reg_wdata_i[pbc_pkg::BIT_PDOWN];
  wire load_straps = srst_i || init_r || chip_rst_busy;

  // ----------------------------------------
  // Write data fields
  // ----------------------------------------
  wire wd_loop = reg_wdata_i[pbc_pkg::BIT_LOOP];
  wire wd_speed = reg_wdata_i[pbc_pkg::BIT_SPEED];
  wire wd_aneg = reg_wdata_i[pbc_pkg::BIT_ANEG];
  wire wd_pdown = reg_wdata_i[pbc_pkg::BIT_PDOWN];
  wire wd_isol = reg_wdata_i[pbc_pkg::BIT_ISOL];
  wire wd_restart = reg_wdata_i[pbc_pkg::BIT_RESTART];
  wire wd_duplex = reg_wdata_i[pbc_pkg::BIT_DUPLEX];
  wire wd_coltest = reg_wdata_i[pbc_pkg::BIT_COLTEST];
  wire [1:0] wd_rsv = reg_wdata_i[1:0];

  pbc_pulse_cnt #(.CYCLES(CHIP_RST_CYCLES)) u_chip_rst (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .start_i(rst_req),
    .busy_o(chip_rst_busy)
  );

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      init_r <= 1'b1;
    end else if (ce_i) begin
      init_r <= 1'b0;
    end
  end

  // Strap defaults reloaded after reset and after soft chip reset
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      loop_r <= 1'b0;
      speed_r <= 1'b0;
      aneg_r <= 1'b0;
      pdown_r <= 1'b0;
      isol_r <= 1'b0;
      restart_r <= 1'b0;
      duplex_r <= 1'b0;
      coltest_r <= 1'b0;
      rsv_r <= pbc_pkg::RSV_RESET;
    end else if (ce_i) begin
      if (load_straps) begin
        loop_r <= 1'b0;
        speed_r <= strap_i.speed;
        aneg_r <= strap_i.aneg;
        pdown_r <= 1'b0;
        isol_r <= strap_i.isolate;
        restart_r <= strap_i.aneg & strap_i.speed;
        duplex_r <= strap_i.duplex;
        coltest_r <= 1'b0;
        rsv_r <= pbc_pkg::RSV_RESET;
      end else if (wr_hit && !rst_req) begin
        loop_r <= wd_loop;
        speed_r <= wd_speed;
        aneg_r <= wd_aneg;
        pdown_r <= wd_pdown;
        isol_r <= wd_isol;
        restart_r <= wd_restart;
        duplex_r <= wd_duplex;
        coltest_r <= wd_coltest;
        rsv_r <= wd_rsv;
      end else begin
        restart_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Power-down exit write guard
  // ----------------------------------------
  pbc_pulse_cnt #(.CYCLES(pbc_pkg::PD_WAIT_CYC)) u_pd_wait (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .start_i(pd_clear),
    .busy_o(pd_busy)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rd_nxt = 16'h0000;
    rd_nxt[pbc_pkg::BIT_RESET] = 1'b0;
    rd_nxt[pbc_pkg::BIT_LOOP] = loop_r;
    rd_nxt[pbc_pkg::BIT_SPEED] = speed_r;
    rd_nxt[pbc_pkg::BIT_ANEG] = aneg_r;
    rd_nxt[pbc_pkg::BIT_PDOWN] = pdown_r;
    rd_nxt[pbc_pkg::BIT_ISOL] = isol_r;
    rd_nxt[pbc_pkg::BIT_RESTART] = restart_r;
    rd_nxt[pbc_pkg::BIT_DUPLEX] = duplex_r;
    rd_nxt[pbc_pkg::BIT_COLTEST] = coltest_r;
    rd_nxt[1:0] = rsv_r;
    if (!hit) begin
      rd_nxt = 16'h0000;
    end
  end

  wire [15:0] rd_masked = rd_nxt & pbc_pkg::WR_MASK;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (ce_i) begin
      reg_rdata_o <= rd_masked;
    end
  end

  // ----------------------------------------
  // Effective mode and datapath steering
  // ----------------------------------------
  wire eff_speed = aneg_r ? 1'b1 : speed_r;
  wire eff_duplex = aneg_r ? 1'b1 : duplex_r;
  wire loop_100 = loop_r && eff_speed;
  wire col_test_on = coltest_r && loop_r;
  wire rx_dv_nxt = loop_r ? tx_en_i : rx_dv_line_i;
  wire [3:0] rxd_nxt = loop_r ? txd_i : rxd_line_i;
  wire col_nxt = col_test_on ? tx_en_i : (!loop_r && col_line_i);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rx_dv_o <= 1'b0;
      rxd_o <= 4'h0;
      col_o <= 1'b0;
      line_tx_en_o <= 1'b0;
    end else if (ce_i) begin
      rx_dv_o <= rx_dv_nxt && !pdown_r;
      rxd_o <= rxd_nxt;
      col_o <= col_nxt && !pdown_r;
      line_tx_en_o <= tx_en_i && !loop_100 && !pdown_r;
    end
  end

  assign mii_oe_o = !isol_r && !pdown_r;
  assign pd_write_block_o = pd_busy;

  assign ctrl_o.chip_reset = chip_rst_busy;
  assign ctrl_o.loopback = loop_r;
  assign ctrl_o.speed_100 = eff_speed;
  assign ctrl_o.full_duplex = eff_duplex;
  assign ctrl_o.aneg_en = aneg_r;
  assign ctrl_o.aneg_restart = restart_r && aneg_r;
  assign ctrl_o.power_down = pdown_r;
  assign ctrl_o.isolate = isol_r;
  assign ctrl_o.col_test = col_test_on;
  assign ctrl_o.line_detach = loop_100 || pdown_r;

endmodule // pbc_ctrl_reg

// *** pbc_ctrl_reg_assertions.sv ***
// Checker for the basic control register
`timescale 1ns/10ps
module pbc_ctrl_reg_assertions #(
  parameter int CHIP_RST_CYCLES = 16
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  input wire logic [3:0] rxd_o,
  input wire logic col_o,
  input wire logic col_line_i,
  input wire logic mii_oe_o,
  input wire logic line_tx_en_o,
  input wire pbc_pkg::pbc_ctrl_t ctrl_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic [7:0] rst_cnt_r;
  wire logic wr0 = ce_i && reg_wr_i && reg_addr_i == 5'h00 && !ctrl_o.chip_reset;
  wire logic live = ctrl_o.loopback && !ctrl_o.isolate && !ctrl_o.power_down;
  always_ff @(posedge mclk_i) begin
    rst_cnt_r <= ctrl_o.chip_reset ? rst_cnt_r + 8'h01 : 8'h00;
  end
  sequence s_restart_wr;
    wr0 && reg_wdata_i[9] ##1 !reg_wr_i && ce_i;
  endsequence
  a_bit15_zero: assert property (!reg_rdata_o[15])
    else $error("bit 15 read as one");
  a_rst_length: assert property ($fell(ctrl_o.chip_reset) |-> rst_cnt_r == CHIP_RST_CYCLES)
    else $error("chip reset length wrong");
  a_detach_line: assert property ((ctrl_o.loopback && ctrl_o.speed_100) [*2] |-> !line_tx_en_o)
    else $error("line transmit active in loopback");
  a_loop_return: assert property (live [*2] |-> rxd_o == $past(txd_i))
    else $error("loopback data not returned");
  a_col_test: assert property ((live && ctrl_o.col_test) [*2] |-> col_o == $past(tx_en_i))
    else $error("collision test output wrong");
  a_col_gate: assert property ((!ctrl_o.loopback) [*2] |->
    col_o == ($past(col_line_i) && !$past(ctrl_o.power_down)))
    else $error("collision test without loopback");
  a_isolate_oe: assert property (ctrl_o.isolate |-> !mii_oe_o)
    else $error("outputs driven while isolated");
  a_aneg_wins: assert property (ctrl_o.aneg_en |-> ctrl_o.speed_100 && ctrl_o.full_duplex)
    else $error("speed or duplex not overridden");
  a_restart_sc: assert property (s_restart_wr |=> !ctrl_o.aneg_restart)
    else $error("restart did not clear");
  a_ro_zero: assert property (reg_rdata_o[6:2] == 5'h00)
    else $error("read-only bits not zero");
endmodule // pbc_ctrl_reg_assertions
bind pbc_ctrl_reg pbc_ctrl_reg_assertions #(.CHIP_RST_CYCLES(CHIP_RST_CYCLES))
  u_chk (.mclk_i, .srst_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
  .reg_rdata_o, .tx_en_i, .txd_i, .rxd_o, .col_o, .col_line_i, .mii_oe_o,
  .line_tx_en_o, .ctrl_o);

// *** pbc_sta_model.sv ***
// Management controller model issuing register accesses
`timescale 1ns/10ps
module pbc_sta_model (
  input wire logic mclk_i,
  input wire logic [15:0] reg_rdata_i,
  output logic [4:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [15:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 5'h1F;
    reg_wr_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge mclk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
    if (a == 5'h00 && !d[11]) repeat (pbc_pkg::PD_WAIT_CYC) @(negedge mclk_i);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    @(negedge mclk_i);
    d = reg_rdata_i;
  endtask
endmodule // pbc_sta_model

// *** pbc_ctrl_reg_tb.sv ***
// Testbench for the basic control register
`timescale 1ns/10ps
module pbc_ctrl_reg_tb;
  logic mclk_i, srst_i, tx_en_i, wr, col_o, mii_oe_o, line_tx_en_o;
  logic [3:0] txd_i, rxd_o;
  logic rx_dv_o, pdb;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, v;
  pbc_pkg::pbc_strap_t strap_i;
  pbc_pkg::pbc_ctrl_t ctrl_o;
  int bad_count = 0;
  int comparisons = 0;
  pbc_ctrl_reg #(.CHIP_RST_CYCLES(2)) u_pbc_ctrl_reg (.mclk_i, .srst_i,
    .ce_i(1'b1), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .strap_i, .tx_en_i, .txd_i, .rx_dv_line_i(1'b0),
    .rxd_line_i(4'h0), .col_line_i(1'b0), .rx_dv_o, .rxd_o, .col_o,
    .mii_oe_o, .line_tx_en_o, .pd_write_block_o(pdb), .ctrl_o);
  pbc_sta_model u_pbc_sta_model (.mclk_i, .reg_rdata_i(rdata),
    .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata));
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic do_rst(input logic [3:0] s);
    @(negedge mclk_i);
    strap_i = s;
    srst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    srst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask
  task automatic t_straps;
    do_rst(4'b1011);
    u_pbc_sta_model.rd(5'h00, v);
    chk(v, 16'h2500);
    chk(mii_oe_o, 1'b0);
    do_rst(4'b0100);
    u_pbc_sta_model.rd(5'h00, v);
    chk(v, 16'h1000);
  endtask
  task automatic t_loop;
    u_pbc_sta_model.wr(5'h00, 16'h6000);
    chk(mii_oe_o, 1'b1);
    tx_en_i = 1'b1;
    txd_i = 4'hA;
    @(negedge mclk_i);
    chk(rxd_o, 4'hA);
    chk(rx_dv_o, 1'b1);
    chk(line_tx_en_o, 1'b0);
    u_pbc_sta_model.wr(5'h00, 16'h40FF);
    u_pbc_sta_model.rd(5'h00, v);
    chk(v, 16'h4083);
    txd_i = 4'h5;
    @(negedge mclk_i);
    chk(rxd_o, 4'h5);
    chk(col_o, 1'b1);
    u_pbc_sta_model.wr(5'h00, 16'h0080);
    chk(col_o, 1'b0);
  endtask
  task automatic t_pdown;
    u_pbc_sta_model.wr(5'h00, 16'h2100);
    u_pbc_sta_model.wr(5'h00, 16'h2900);
    u_pbc_sta_model.wr(5'h00, 16'h2100);
    chk(pdb, 1'b0);
    u_pbc_sta_model.rd(5'h00, v);
    chk(v, 16'h2100);
    u_pbc_sta_model.wr(5'h00, 16'h8000);
    u_pbc_sta_model.rd(5'h00, v);
    chk(v, 16'h1000);
  endtask
  task automatic t_restart;
    u_pbc_sta_model.wr(5'h00, 16'h1200);
    u_pbc_sta_model.rd(5'h00, v);
    chk(v, 16'h1000);
    chk(ctrl_o.speed_100, 1'b1);
    chk(ctrl_o.full_duplex, 1'b1);
    u_pbc_sta_model.wr(5'h01, 16'hFFFF);
    u_pbc_sta_model.rd(5'h01, v);
    chk(v, 16'h0000);
    u_pbc_sta_model.rd(5'h00, v);
    chk(v, 16'h1000);
  endtask
  initial begin
    srst_i = 1'b1;
    tx_en_i = 1'b0;
    txd_i = 4'h0;
    strap_i = 4'h0;
    t_straps;
    t_loop;
    t_pdown;
    t_restart;
    wrap_up;
  end
  initial begin
    #40000;
    bad_count++;
    wrap_up;
  end
endmodule // pbc_ctrl_reg_tb
